// >>> shared/sfed_pkg.sv
// Shared constants and carriers for the SIMD floating-point exception unit.
// Assumes a 32-bit APB slave port and a datapath that classifies each element.
package sfed_pkg;

    localparam int ELEM_W = 32;
    localparam int NUM_COND = 6;

    // Condition index doubles as the flag bit position; the mask sits seven bits higher.
    localparam int COND_INVALID = 0;
    localparam int COND_DENORMAL = 1;
    localparam int COND_DIVZERO = 2;
    localparam int COND_OVERFLOW = 3;
    localparam int COND_UNDERFLOW = 4;
    localparam int COND_INEXACT = 5;
    localparam int MASK_SHIFT = 7;

    localparam int DENORM_ZERO_BIT = 6;
    localparam int FTZ_BIT = 15;
    localparam int OS_SUPPORT_BIT = 10;

    localparam logic [5:0] PRE_CONDS = 6'h07;
    localparam logic [5:0] POST_CONDS = 6'h38;

    localparam logic [31:0] CSR_WR_MASK = 32'h0000_ffff;
    localparam logic [31:0] CSR_RESET = 32'h0000_1f80;
    localparam logic [31:0] SYS_WR_MASK = 32'h0000_0400;
    localparam logic [31:0] SYS_RESET = 32'h0000_0000;

    localparam logic [11:0] ADDR_CSR = 12'h000;
    localparam logic [11:0] ADDR_SYS = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;

    localparam int STAT_BUSY = 0;
    localparam int STAT_PRE_WAIT = 1;
    localparam int STAT_POST_WAIT = 2;

    // One element as classified by the arithmetic datapath.
    typedef struct packed {
        logic invalid;
        logic denormal;
        logic is_divide;
        logic dividend_fin_nz;
        logic divisor_zero;
        logic overflow;
        logic tiny;
        logic inexact;
        logic sign;
        logic [ELEM_W-1:0] result;
    } sfed_elem_s;

    typedef enum logic [2:0] {
        S_IDLE,
        S_PRE,
        S_PRE_WAIT,
        S_POST,
        S_POST_WAIT,
        S_DONE
    } sfed_state_e;

endpackage

// >>> rtl/sfed_elem_detect.sv
// Condition detection and masked result for one element.
// Assumes the element classification is stable while the unit is busy.
`timescale 1ns/1ps
module sfed_elem_detect (
    input wire sfed_pkg::sfed_elem_s elem_i,
    input wire logic denorm_zero_i,
    input wire logic ftz_i,
    input wire logic uf_mask_i,
    output logic [5:0] cond_o,
    output logic [sfed_pkg::ELEM_W-1:0] result_o
);
    import sfed_pkg::*;

    logic flush;

    always_comb
    begin
        cond_o = '0;
        cond_o[COND_INVALID] = elem_i.invalid;
        // Zeroed denormal inputs no longer count as denormal operands.
        cond_o[COND_DENORMAL] = elem_i.denormal & ~denorm_zero_i;
        // Neither flush nor input zeroing takes part here.
        cond_o[COND_DIVZERO] = elem_i.is_divide & elem_i.dividend_fin_nz & elem_i.divisor_zero;
        cond_o[COND_OVERFLOW] = elem_i.overflow;
        // Masked underflow needs a lossy result; an exact tiny one leaves the flag alone.
        cond_o[COND_UNDERFLOW] = elem_i.tiny & (uf_mask_i ? elem_i.inexact : 1'b1);
        cond_o[COND_INEXACT] = elem_i.inexact;
    end

    assign flush = ftz_i & uf_mask_i & elem_i.tiny;
    assign result_o = flush ? {elem_i.sign, {(ELEM_W-1){1'b0}}} : elem_i.result;

endmodule

// >>> rtl/sfed_trap_select.sv
// Chooses which trap a detected unmasked condition raises.
// Assumes fire_i is a single-cycle request from the sequencer.
`timescale 1ns/1ps
module sfed_trap_select (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic fire_i,
    input wire logic os_support_i,
    output logic simd_fp_trap_o,
    output logic invalid_opcode_trap_o
);
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            simd_fp_trap_o <= 1'b0;
            invalid_opcode_trap_o <= 1'b0;
        end
        else
        begin
            simd_fp_trap_o <= fire_i & os_support_i;
            invalid_opcode_trap_o <= fire_i & ~os_support_i;
        end
    end

endmodule

// >>> rtl/simd_fp_exception_detect.sv
// SIMD floating-point exception detection, flagging and trap sequencing.
// Assumes the datapath holds the element classification steady from request to done.
`timescale 1ns/1ps
module simd_fp_exception_detect #(
    parameter int NUM_ELEM = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire sfed_pkg::sfed_elem_s [NUM_ELEM-1:0] elem_i,
    input wire logic handler_return_i,
    output logic simd_fp_trap_o,
    output logic invalid_opcode_trap_o,
    output logic [NUM_ELEM*sfed_pkg::ELEM_W-1:0] dest_data_o,
    output logic dest_we_o,
    output logic done_o
);
    import sfed_pkg::*;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return (res & wmask) | (old_v & ~wmask);
    endfunction

    logic [31:0] csr_q;
    logic [31:0] csr_d;
    logic [31:0] sys_q;
    sfed_state_e state_q;
    sfed_state_e state_d;
    logic [NUM_ELEM*ELEM_W-1:0] dest_q;
    logic dest_we_q;
    logic done_q;
    logic [5:0] elem_cond [NUM_ELEM];
    logic [NUM_ELEM*ELEM_W-1:0] elem_res;
    logic [5:0] cond_any;
    logic [5:0] masks;
    logic [5:0] flag_set;
    logic pre_unmasked;
    logic post_unmasked;
    logic fire;
    logic wr_en;
    logic rd_ok;
    logic csr_wr;
    logic sys_wr;

    assign masks = csr_q[MASK_SHIFT +: NUM_COND];

    for (genvar e = 0; e < NUM_ELEM; e++)
    begin : g_elem
        sfed_elem_detect u_detect (
            .elem_i(elem_i[e]),
            .denorm_zero_i(csr_q[DENORM_ZERO_BIT]),
            .ftz_i(csr_q[FTZ_BIT]),
            .uf_mask_i(masks[COND_UNDERFLOW]),
            .cond_o(elem_cond[e]),
            .result_o(elem_res[e*ELEM_W +: ELEM_W])
        );
    end

    // Each element keeps its own conditions; the status flags see their OR.
    always_comb
    begin
        cond_any = '0;
        for (int e = 0; e < NUM_ELEM; e++)
        begin
            cond_any = cond_any | elem_cond[e];
        end
    end

    assign pre_unmasked = |(cond_any & PRE_CONDS & ~masks);
    assign post_unmasked = |(cond_any & POST_CONDS & ~masks);

    // Flags for masked and unmasked conditions are raised together in each phase.
    always_comb
    begin
        flag_set = '0;
        if (state_q == S_PRE)
        begin
            flag_set = cond_any & PRE_CONDS;
        end
        else if (state_q == S_POST)
        begin
            flag_set = cond_any & POST_CONDS;
        end
    end

    assign fire = (state_q == S_PRE && pre_unmasked) || (state_q == S_POST && post_unmasked);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
            begin
                if (req_valid_i)
                begin
                    state_d = S_PRE;
                end
            end
            S_PRE:
            begin
                state_d = pre_unmasked ? S_PRE_WAIT : S_POST;
            end
            S_PRE_WAIT:
            begin
                if (handler_return_i)
                begin
                    state_d = S_POST;
                end
            end
            S_POST:
            begin
                state_d = post_unmasked ? S_POST_WAIT : S_DONE;
            end
            S_POST_WAIT:
            begin
                if (handler_return_i)
                begin
                    state_d = S_DONE;
                end
            end
            S_DONE:
            begin
                state_d = S_IDLE;
            end
            default:
            begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= S_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Operands stay untouched during traps; results land only when the instruction completes.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dest_q <= '0;
            dest_we_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            dest_we_q <= (state_q == S_DONE);
            done_q <= (state_q == S_DONE);
            if (state_q == S_DONE)
            begin
                dest_q <= elem_res;
            end
        end
    end

    sfed_trap_select u_trap (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .fire_i(fire),
        .os_support_i(sys_q[OS_SUPPORT_BIT]),
        .simd_fp_trap_o(simd_fp_trap_o),
        .invalid_opcode_trap_o(invalid_opcode_trap_o)
    );

    // APB: zero wait states; unmapped addresses and writes to the status word are errored.
    assign wr_en = psel_i & penable_i & pwrite_i;
    assign csr_wr = wr_en && paddr_i == ADDR_CSR;
    assign sys_wr = wr_en && paddr_i == ADDR_SYS;

    always_comb
    begin
        rd_ok = 1'b1;
        prdata_o = '0;
        if (paddr_i == ADDR_CSR)
        begin
            prdata_o = csr_q;
        end
        else if (paddr_i == ADDR_SYS)
        begin
            prdata_o = sys_q;
        end
        else if (paddr_i == ADDR_STAT)
        begin
            prdata_o[STAT_BUSY] = (state_q != S_IDLE);
            prdata_o[STAT_PRE_WAIT] = (state_q == S_PRE_WAIT);
            prdata_o[STAT_POST_WAIT] = (state_q == S_POST_WAIT);
            rd_ok = ~pwrite_i;
        end
        else
        begin
            rd_ok = 1'b0;
        end
    end

    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~rd_ok;

    // A hardware set in the same cycle as a software clear wins.
    always_comb
    begin
        csr_d = csr_q;
        if (csr_wr)
        begin
            csr_d = merge_bytes(csr_q, pwdata_i, pstrb_i, CSR_WR_MASK);
        end
        csr_d[NUM_COND-1:0] = csr_d[NUM_COND-1:0] | flag_set;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            csr_q <= CSR_RESET;
        end
        else
        begin
            csr_q <= csr_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sys_q <= SYS_RESET;
        end
        else if (sys_wr)
        begin
            sys_q <= merge_bytes(sys_q, pwdata_i, pstrb_i, SYS_WR_MASK);
        end
    end

    assign req_ready_o = (state_q == S_IDLE);
    assign dest_data_o = dest_q;
    assign dest_we_o = dest_we_q;
    assign done_o = done_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_trap_simd_sel: assert property (fire |=> simd_fp_trap_o == sys_q[OS_SUPPORT_BIT])
        else $error("SIMD trap does not follow OS support bit");
    chk_trap_undef_sel: assert property (invalid_opcode_trap_o |-> !simd_fp_trap_o && !$past(sys_q[OS_SUPPORT_BIT]))
        else $error("Invalid-opcode trap raised with OS support set");
    chk_no_write_trap: assert property ((simd_fp_trap_o || invalid_opcode_trap_o) |-> !dest_we_o)
        else $error("Destination written during a trap");
    chk_pre_before_post: assert property ($rose(state_q == S_POST) |-> $past(state_q) inside {S_PRE, S_PRE_WAIT})
        else $error("Post checks entered without pre checks");
    chk_divzero_flag: assert property (state_q == S_PRE && cond_any[COND_DIVZERO] |=> csr_q[COND_DIVZERO])
        else $error("Divide-by-zero flag not set");
    chk_ovf_flag: assert property (state_q == S_POST && cond_any[COND_OVERFLOW] |=> csr_q[COND_OVERFLOW])
        else $error("Overflow flag not set");
    chk_flag_sticky: assert property (csr_q[COND_INEXACT] && !csr_wr |=> csr_q[COND_INEXACT])
        else $error("Inexact flag dropped without software write");
    chk_trap_waits: assert property (fire |=> (state_q inside {S_PRE_WAIT, S_POST_WAIT})[*1])
        else $error("Trap raised without waiting for handler");
    chk_write_done: assert property (state_q == S_DONE |=> dest_we_o && done_o ##1 !dest_we_o)
        else $error("Masked results not written once at completion");

    // Every condition seen in its own phase must be recorded by the next edge, masked or not.
    chk_invalid_flag: assert property (state_q == S_PRE && cond_any[COND_INVALID] |=> csr_q[COND_INVALID])
        else $error("Invalid flag not set");
    chk_denorm_flag: assert property (state_q == S_PRE && cond_any[COND_DENORMAL] |=> csr_q[COND_DENORMAL])
        else $error("Denormal flag not set");
    chk_uf_flag: assert property (state_q == S_POST && cond_any[COND_UNDERFLOW] |=> csr_q[COND_UNDERFLOW])
        else $error("Underflow flag not set");
    chk_inexact_flag: assert property (state_q == S_POST && cond_any[COND_INEXACT] |=> csr_q[COND_INEXACT])
        else $error("Inexact flag not set");

    // Trap outputs are single pulses of one kind, so the handler is entered once per phase.
    chk_trap_exclusive: assert property (!(simd_fp_trap_o && invalid_opcode_trap_o))
        else $error("Both trap kinds raised together");
    chk_trap_pulse: assert property ((simd_fp_trap_o || invalid_opcode_trap_o) |=> !(simd_fp_trap_o || invalid_opcode_trap_o))
        else $error("Trap pulse longer than one cycle");
    chk_masked_pre: assert property (state_q == S_PRE && !pre_unmasked |=> !simd_fp_trap_o && !invalid_opcode_trap_o)
        else $error("Trap raised for masked pre-computation conditions");
    chk_masked_post: assert property (state_q == S_POST && !post_unmasked |=> !simd_fp_trap_o && !invalid_opcode_trap_o)
        else $error("Trap raised for masked post-computation conditions");

    // The destination only moves at completion; a handler always sees the old operands.
    chk_dest_stable: assert property (state_q != S_DONE |=> $stable(dest_data_o))
        else $error("Destination changed before completion");
    chk_pre_wait_hold: assert property (state_q == S_PRE_WAIT && !handler_return_i |=> state_q == S_PRE_WAIT)
        else $error("Pre-computation wait left without handler return");
    chk_post_after_ret: assert property (state_q == S_PRE_WAIT && handler_return_i |=> state_q == S_POST)
        else $error("Post checks not entered after handler return");

endmodule

// >>> testbench/simd_fp_exception_detect_tb_top.sv
// Self-checking bench for the SIMD floating-point exception unit.
// Assumes the APB slave answers with zero or more wait states and that the bench plays the datapath and trap handler.
`timescale 1ns/1ps
module simd_fp_exception_detect_tb_top;
    import sfed_pkg::*;
    localparam int NE = 4;
    // Element codes: invalid, denormal, divide, finite nonzero dividend, zero divisor, overflow, tiny, inexact, sign.
    localparam logic [8:0] C_INV = 9'h100;
    localparam logic [8:0] C_DZ = 9'h070;
    localparam logic [8:0] C_ZZ = 9'h050;
    localparam logic [8:0] C_DEN = 9'h080;
    localparam logic [8:0] C_OVF = 9'h008;
    localparam logic [8:0] C_TINY = 9'h004;
    localparam logic [8:0] C_TNX = 9'h006;
    localparam logic [8:0] C_NEG = 9'h001;
    logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic req_valid_i, req_ready_o, handler_return_i;
    logic simd_fp_trap_o, invalid_opcode_trap_o, dest_we_o, done_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic [31:0] rd;
    logic [3:0] pstrb_i;
    logic err;
    sfed_elem_s [NE-1:0] elem_i;
    logic [NE*ELEM_W-1:0] dest_data_o;
    int err_total;
    int n_checks;

    simd_fp_exception_detect #(.NUM_ELEM(NE)) i_dut (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o),
        .elem_i(elem_i),
        .handler_return_i(handler_return_i),
        .simd_fp_trap_o(simd_fp_trap_o),
        .invalid_opcode_trap_o(invalid_opcode_trap_o),
        .dest_data_o(dest_data_o),
        .dest_we_o(dest_we_o),
        .done_o(done_o)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task final_report;
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, wr, a, wd};
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge clk_i);
            if (pready_o === 1'b1)
                break;
        end
        rd = prdata_o;
        err = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
        if (n == 16)
        begin
            err_total++;
            final_report();
        end
    endtask

    task rreg(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk($sformatf("register %h", a), rd, exp);
    endtask

    // Runs one instruction; every trap is answered by a handler return three cycles later.
    task op(input logic [35:0] cs, input int ntr, input logic os);
        int n;
        int pend;
        int seen;
        logic moved;
        logic [NE*ELEM_W-1:0] d0;
        pend = 0;
        seen = 0;
        moved = 1'b0;
        @(posedge clk_i);
        for (int e = 0; e < NE; e++)
        begin
            elem_i[e] <= {cs[e*9+:9], 32'(32'h0000_1111 * (e + 1))};
        end
        req_valid_i <= 1'b1;
        d0 = dest_data_o;
        for (n = 0; n < 8; n++)
        begin
            @(posedge clk_i);
            if (req_ready_o === 1'b1)
                break;
        end
        req_valid_i <= 1'b0;
        if (n == 8)
        begin
            err_total++;
            final_report();
        end
        for (n = 0; n < 200; n++)
        begin
            @(posedge clk_i);
            handler_return_i <= (pend == 1);
            if (pend > 0)
                pend--;
            if (simd_fp_trap_o === 1'b1 || invalid_opcode_trap_o === 1'b1)
            begin
                seen++;
                pend = 3;
                chk("trap kind", {30'h0, simd_fp_trap_o, invalid_opcode_trap_o}, {30'h0, os, ~os});
            end
            if (dest_we_o !== done_o)
                moved = 1'b1;
            if (done_o === 1'b1)
                break;
            if (dest_data_o !== d0)
                moved = 1'b1;
        end
        if (n == 200)
        begin
            err_total++;
            final_report();
        end
        chk("trap count", 32'(seen), 32'(ntr));
        chk("dest held", {31'h0, moved}, 32'h0000_0000);
    endtask

    initial
    begin
        {rst_n_i, psel_i, penable_i, pwrite_i, req_valid_i, handler_return_i} = 6'h00;
        paddr_i = 12'h000;
        pwdata_i = 32'h0000_0000;
        pstrb_i = 4'hf;
        elem_i = '0;
        err_total = 0;
        n_checks = 0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rreg(ADDR_CSR, 32'h0000_1f80);
        rreg(ADDR_SYS, 32'h0000_0000);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk("unmapped error", {31'h0, err}, 32'h0000_0001);
        rreg(ADDR_STAT, 32'h0000_0000);
        apb(1'b1, ADDR_STAT, 32'h0000_0007);
        chk("status write error", {31'h0, err}, 32'h0000_0001);
        // Invalid, divide-by-zero, zero-over-zero and denormal lanes, all masked: no trap, three flags set.
        op({C_INV, C_DZ, C_ZZ, C_DEN}, 0, 1'b1);
        rreg(ADDR_CSR, 32'h0000_1f87);
        op(36'h0, 0, 1'b1);
        rreg(ADDR_CSR, 32'h0000_1f87);
        apb(1'b1, ADDR_CSR, 32'h0000_9f80);
        op({27'h0, C_TINY}, 0, 1'b1);
        rreg(ADDR_CSR, 32'h0000_9f80);
        chk("flushed lane 0", dest_data_o[31:0], 32'h0000_0000);
        op({18'h0, C_TNX | C_NEG, 9'h000}, 0, 1'b1);
        rreg(ADDR_CSR, 32'h0000_9fb0);
        chk("flushed lane 1", dest_data_o[63:32], 32'h8000_0000);
        chk("plain lane 0", dest_data_o[31:0], 32'h0000_1111);
        apb(1'b1, ADDR_CSR, 32'h0000_9fc0);
        op({C_OVF, 18'h0, C_DZ}, 0, 1'b1);
        rreg(ADDR_CSR, 32'h0000_9fcc);
        // Divide by zero, overflow and underflow unmasked; denormal and inexact stay masked.
        apb(1'b1, ADDR_SYS, 32'h0000_0400);
        apb(1'b1, ADDR_CSR, 32'h0000_1180);
        op({C_DEN, C_TNX, C_TINY, C_DZ}, 2, 1'b1);
        rreg(ADDR_CSR, 32'h0000_11b6);
        apb(1'b1, ADDR_SYS, 32'h0000_0000);
        apb(1'b1, ADDR_CSR, 32'h0000_1180);
        op({27'h0, C_DZ}, 1, 1'b0);
        rreg(ADDR_CSR, 32'h0000_1184);
        final_report();
    end
endmodule
